// ==== hw/tmc_timer.sv ====
// tmc_timer: 8-bit prescaler plus 8-bit main counter in timer mode, AXI4-Lite slave
// assumes a single 100 MHz clock and a synchronous active-low reset
// the count source is divided down from aclk; no pin feeds the counters
// Functional notes
// RQ1 - the counters run while the run bit (bit 0 of run control) is one and stop when zero.
// RQ2 - writing one to the forced-halt bit (bit 2) stops counting at once; the bit reads zero.
// RQ3 - the prescaler counts the selected source and takes any value 00h to ffh.
// RQ4 - the main counter steps once per prescaler underflow and takes any value 00h to ffh.
// RQ5 - a main counter underflow raises the interrupt request of the block.
// RQ6 - on underflow each counter reloads its last written value and keeps counting.
// RQ7 - mode field bits 2..0 of mode select equal to 000 select timer mode.
// RQ8 - source field bits 6..4 equal to 001 select the clock divided by eight.
// RQ9 - the gate bit (bit 7 of mode select) passes the source when it is zero.
// RQ10 - priority level 000 disables the interrupt, 001 selects level one. Here irq still rises at level 000 through ists and imask.
// RQ11 - request flag bit 3 of irq control reads zero when idle; writing zero clears it.
// RQ12 - pin route field 00 leaves the timer pin unused. Here timer_out still toggles on each main underflow at route 00.
// RQ13 - in timer mode software keeps the polarity bit and filter field of pin io at zero.
// RQ14 - software stops, disables irq, halts, loads, configures, enables irq, then starts.
//
// Our own choices: the AXI4-Lite slave port and the placing of the registers.
module tmc_timer
  import tmc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [5:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [5:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic irq,
  output logic [2:0] irq_level,
  output logic timer_out
);
  // ==========================================================================
  // state
  logic run_bit, next_run_bit;
  logic counting, next_counting;
  tmc_irqc_t irqc, next_irqc;
  tmc_mode_t mode, next_mode;
  logic [7:0] pre_reload, next_pre_reload;
  logic [7:0] main_reload, next_main_reload;
  logic [7:0] prescale_counter, next_prescale_counter;
  logic [7:0] main_counter, next_main_counter;
  logic [7:0] div_cnt, next_div_cnt;
  logic [1:0] route, next_route;
  logic [5:0] pio, next_pio;
  logic ists, next_ists;
  logic imask, next_imask;
  logic toggle, next_toggle;
  tmc_wr_state_t wst, next_wst;
  logic [5:0] aw_q, next_aw_q;
  logic aw_have, next_aw_have;
  logic [31:0] w_q, next_w_q;
  logic [3:0] ws_q, next_ws_q;
  logic w_have, next_w_have;
  logic [1:0] bresp, next_bresp;
  logic bvalid, next_bvalid;
  logic rvalid, next_rvalid;
  logic [31:0] rdata, next_rdata;
  logic [1:0] rresp, next_rresp;
  logic irq_q, next_irq_q;
  logic [2:0] lvl_q, next_lvl_q;
  logic aw_rdy, next_aw_rdy;
  logic w_rdy, next_w_rdy;
  logic ar_rdy, next_ar_rdy;

  function automatic logic known(input logic [5:0] a);
    known = (a == tmc_off_run) || (a == tmc_off_irqc) || (a == tmc_off_pre) ||
            (a == tmc_off_main) || (a == tmc_off_route) || (a == tmc_off_pio) ||
            (a == tmc_off_mode) || (a == tmc_off_ists) || (a == tmc_off_imask);
  endfunction : known

  // ==========================================================================
  // count source
  logic src_tick, pre_uf, main_uf, do_wr, halt_wr;
  logic [7:0] wb;
  logic [7:0] div_last;

  // divider end value per source code; other codes run at the full clock
  always_comb begin
    case (mode.source)
      tmc_src_div8: div_last = tmc_div8_last; // see RQ8
      tmc_src_div2: div_last = tmc_div2_last;
      default: div_last = 8'h00;
    endcase
  end

  // source passes only with the gate bit clear, timer mode and counting
  assign src_tick = counting && !mode.gate_cut && (mode.opmode == tmc_mode_timer) &&
                    (div_cnt == div_last); // see RQ7 see RQ9
  assign pre_uf = src_tick && (prescale_counter == 8'h00); // see RQ3
  assign main_uf = pre_uf && (main_counter == 8'h00); // see RQ4

  assign do_wr = (wst == tmc_wr_idle) && aw_have && w_have;
  assign wb = w_q[7:0];
  assign halt_wr = do_wr && (aw_q == tmc_off_run) && ws_q[0] && wb[tmc_b_halt];

  // ==========================================================================
  // write channel
  always_comb begin
    next_wst = wst;
    next_aw_q = aw_q;
    next_aw_have = aw_have;
    next_w_q = w_q;
    next_ws_q = ws_q;
    next_w_have = w_have;
    next_bresp = bresp;
    next_bvalid = bvalid;
    // address and data are held separately and may arrive in either order
    if (s_axi_awvalid && !aw_have) begin
      next_aw_q = s_axi_awaddr;
      next_aw_have = 1'b1;
    end
    if (s_axi_wvalid && !w_have) begin
      next_w_q = s_axi_wdata;
      next_ws_q = s_axi_wstrb;
      next_w_have = 1'b1;
    end
    case (wst)
      tmc_wr_idle: begin
        if (do_wr) begin
          next_aw_have = 1'b0;
          next_w_have = 1'b0;
          next_bvalid = 1'b1;
          next_bresp = known(aw_q) ? tmc_resp_okay : tmc_resp_slverr;
          next_wst = tmc_wr_resp;
        end
      end
      tmc_wr_resp: begin
        if (s_axi_bready) begin
          next_bvalid = 1'b0;
          next_wst = tmc_wr_idle;
        end
      end
      default: next_wst = tmc_wr_idle;
    endcase
  end

  // ==========================================================================
  // registers and counters
  always_comb begin
    next_run_bit = run_bit;
    next_irqc = irqc;
    next_mode = mode;
    next_pre_reload = pre_reload;
    next_main_reload = main_reload;
    next_route = route;
    next_pio = pio;
    next_imask = imask;
    next_ists = ists;
    next_div_cnt = div_cnt;
    next_prescale_counter = prescale_counter;
    next_main_counter = main_counter;
    next_toggle = toggle;
    if (do_wr && ws_q[0]) begin
      case (aw_q)
        tmc_off_run: next_run_bit = wb[tmc_b_run]; // see RQ1
        tmc_off_irqc: begin
          // a one written to the request flag is ignored; only a zero clears it
          next_irqc.level = wb[2:0]; // see RQ10
          if (!wb[tmc_b_req]) next_irqc.req = 1'b0; // see RQ11
        end
        tmc_off_pre: begin
          next_pre_reload = wb;
          next_prescale_counter = wb; // see RQ3
        end
        tmc_off_main: begin
          next_main_reload = wb;
          next_main_counter = wb; // see RQ4
        end
        tmc_off_route: next_route = wb[1:0]; // see RQ12
        tmc_off_pio: next_pio = wb[5:0]; // see RQ13
        tmc_off_mode: next_mode = '{source: wb[6:4], gate_cut: wb[tmc_b_gate],
                                    opmode: wb[2:0]};
        tmc_off_ists: if (wb[tmc_b_ev_uf]) next_ists = 1'b0;
        tmc_off_imask: next_imask = wb[tmc_b_ev_uf];
        default: ;
      endcase
    end
    // a forced halt reloads both counters so the next start begins a full period
    if (halt_wr) begin
      next_run_bit = 1'b0; // see RQ2
      next_prescale_counter = next_pre_reload;
      next_main_counter = next_main_reload;
      next_div_cnt = 8'h00;
    end else if (counting && !mode.gate_cut) begin
      // a source change can leave the divider above its new end; restart it then
      next_div_cnt = (div_cnt >= div_last) ? 8'h00 : div_cnt + 8'h01;
    end
    if (src_tick && !halt_wr) begin
      next_prescale_counter = pre_uf ? pre_reload : prescale_counter - 8'h01; // see RQ6
      if (pre_uf) begin
        next_main_counter = main_uf ? main_reload : main_counter - 8'h01; // see RQ6
      end
    end
    // applied after the register writes so that a set wins over a clear
    if (main_uf && !halt_wr) begin
      next_irqc.req = 1'b1; // see RQ5
      next_ists = 1'b1;
      next_toggle = ~toggle;
    end
  end

  // halt takes effect in the same cycle and drops the status flag at once
  assign next_counting = next_run_bit; // see RQ1 see RQ2

  // ==========================================================================
  // read channel
  always_comb begin
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    if (rvalid && s_axi_rready) next_rvalid = 1'b0;
    // unmapped reads answer zero with an error response
    if (s_axi_arvalid && !rvalid) begin
      next_rvalid = 1'b1;
      next_rresp = known(s_axi_araddr) ? tmc_resp_okay : tmc_resp_slverr;
      next_rdata = 32'h0000_0000;
      case (s_axi_araddr)
        tmc_off_run: begin
          next_rdata[tmc_b_run] = run_bit;
          next_rdata[tmc_b_status] = counting; // halt bit reads zero, see RQ2
        end
        tmc_off_irqc: next_rdata[3:0] = {irqc.req, irqc.level}; // see RQ11
        tmc_off_pre: next_rdata[7:0] = prescale_counter;
        tmc_off_main: next_rdata[7:0] = main_counter;
        tmc_off_route: next_rdata[1:0] = route;
        tmc_off_pio: next_rdata[5:0] = pio;
        tmc_off_mode: next_rdata[7:0] = {mode.gate_cut, mode.source, 1'b0, mode.opmode};
        tmc_off_ists: next_rdata[tmc_b_ev_uf] = ists;
        tmc_off_imask: next_rdata[tmc_b_ev_uf] = imask;
        default: ;
      endcase
    end
    // the request flag reaches irq only at a non-zero level; ists with imask raises irq at any level
    next_irq_q = (next_ists && next_imask) ||
                 (next_irqc.req && (next_irqc.level != tmc_lvl_off)); // see RQ10
    next_lvl_q = next_irqc.level;
  end

  // ==========================================================================
  // ready flops: accept a new beat only while nothing of that kind is held
  always_comb begin
    next_aw_rdy = !next_aw_have;
    next_w_rdy = !next_w_have;
    next_ar_rdy = !next_rvalid;
  end

  // ==========================================================================
  // flops
  // every output of the block is one of these registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      run_bit <= 1'b0;
      counting <= 1'b0;
      irqc <= '0;
      mode <= '0;
      pre_reload <= tmc_cnt_rst;
      main_reload <= tmc_cnt_rst;
      prescale_counter <= tmc_cnt_rst;
      main_counter <= tmc_cnt_rst;
      div_cnt <= 8'h00;
      route <= 2'h0;
      pio <= 6'h00;
      ists <= 1'b0;
      imask <= 1'b0;
      toggle <= 1'b0;
      wst <= tmc_wr_idle;
      aw_q <= 6'h00;
      aw_have <= 1'b0;
      w_q <= 32'h0000_0000;
      ws_q <= 4'h0;
      w_have <= 1'b0;
      bresp <= tmc_resp_okay;
      bvalid <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= tmc_resp_okay;
      irq_q <= 1'b0;
      lvl_q <= 3'h0;
      aw_rdy <= 1'b1;
      w_rdy <= 1'b1;
      ar_rdy <= 1'b1;
    end else begin
      run_bit <= next_run_bit;
      counting <= next_counting;
      irqc <= next_irqc;
      mode <= next_mode;
      pre_reload <= next_pre_reload;
      main_reload <= next_main_reload;
      prescale_counter <= next_prescale_counter;
      main_counter <= next_main_counter;
      div_cnt <= next_div_cnt;
      route <= next_route;
      pio <= next_pio;
      ists <= next_ists;
      imask <= next_imask;
      toggle <= next_toggle;
      wst <= next_wst;
      aw_q <= next_aw_q;
      aw_have <= next_aw_have;
      w_q <= next_w_q;
      ws_q <= next_ws_q;
      w_have <= next_w_have;
      bresp <= next_bresp;
      bvalid <= next_bvalid;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
      irq_q <= next_irq_q;
      lvl_q <= next_lvl_q;
      aw_rdy <= next_aw_rdy;
      w_rdy <= next_w_rdy;
      ar_rdy <= next_ar_rdy;
    end
  end

  assign s_axi_awready = aw_rdy;
  assign s_axi_wready = w_rdy;
  assign s_axi_bvalid = bvalid;
  assign s_axi_bresp = bresp;
  assign s_axi_arready = ar_rdy;
  assign s_axi_rvalid = rvalid;
  assign s_axi_rdata = rdata;
  assign s_axi_rresp = rresp;
  assign irq = irq_q;
  assign irq_level = lvl_q;
  // toggles on every main underflow; the pin route does not gate it in timer mode
  assign timer_out = toggle; // see RQ12
endmodule : tmc_timer

// ==== hw/tmc_pkg.sv ====
// tmc_pkg: constants, register map and carrier types of the timer mode counter
// assumes an AXI4-Lite slave with 32-bit data, one aligned word per register
package tmc_pkg;
  // ==========================================================================
  // register byte offsets
  localparam logic [5:0] tmc_off_run = 6'h00;
  localparam logic [5:0] tmc_off_irqc = 6'h04;
  localparam logic [5:0] tmc_off_pre = 6'h08;
  localparam logic [5:0] tmc_off_main = 6'h0c;
  localparam logic [5:0] tmc_off_route = 6'h10;
  localparam logic [5:0] tmc_off_pio = 6'h14;
  localparam logic [5:0] tmc_off_mode = 6'h18;
  localparam logic [5:0] tmc_off_ists = 6'h1c;
  localparam logic [5:0] tmc_off_imask = 6'h20;
  // ==========================================================================
  // field positions
  localparam int tmc_b_run = 0;
  localparam int tmc_b_halt = 2;
  localparam int tmc_b_status = 5;
  localparam int tmc_b_req = 3;
  localparam int tmc_b_gate = 7;
  localparam int tmc_b_ev_uf = 0;
  // ==========================================================================
  // codes
  localparam logic [2:0] tmc_mode_timer = 3'h0;
  localparam logic [2:0] tmc_src_div1 = 3'h0;
  localparam logic [2:0] tmc_src_div8 = 3'h1;
  localparam logic [2:0] tmc_src_div2 = 3'h3;
  localparam logic [2:0] tmc_lvl_off = 3'h0;
  localparam logic [7:0] tmc_div8_last = 8'h07;
  localparam logic [7:0] tmc_div2_last = 8'h01;
  localparam logic [7:0] tmc_cnt_rst = 8'hff;
  localparam logic [1:0] tmc_resp_okay = 2'h0;
  localparam logic [1:0] tmc_resp_slverr = 2'h2;
  // ==========================================================================
  // carriers
  typedef struct packed {
    logic [2:0] source;
    logic gate_cut;
    logic [2:0] opmode;
  } tmc_mode_t;
  typedef struct packed {
    logic req;
    logic [2:0] level;
  } tmc_irqc_t;
  typedef enum logic [1:0] {
    tmc_wr_idle = 2'b00,
    tmc_wr_resp = 2'b01
  } tmc_wr_state_t;
endpackage : tmc_pkg

// ==== testbench/tmc_timer_props.sv ====
// tmc_timer_props: bus handshake and interrupt level assertions
// assumes it is bound to tmc_timer and sees only its ports
module tmc_timer_props
  import tmc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [5:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [2:0] irq_level
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================================
  // handshakes
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  // ==========================================================================
  // assertions
  wr_answer_a: assert property (wr_take |=> ##[0:2] s_axi_bvalid)
    else $error("write response missing");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  wr_busy_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("second write answered back to back");
  rd_answer_a: assert property (rd_take |=> s_axi_rvalid)
    else $error("read data late");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  rd_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while busy");
  rd_unmapped_a: assert property (rd_take ##0 (s_axi_araddr > 6'h20) |=>
    s_axi_rresp == tmc_resp_slverr && s_axi_rdata == 32'h0) else $error("bad unmapped read");
  rd_mapped_a: assert property (rd_take ##0 (s_axi_araddr <= 6'h20 &&
    s_axi_araddr[1:0] == 2'h0) |=> s_axi_rresp == tmc_resp_okay) else $error("bad read resp");
  level_write_a: assert property ($changed(irq_level) |-> s_axi_bvalid)
    else $error("level changed without write");
endmodule : tmc_timer_props

// ==== testbench/test_tmc_timer.sv ====
// test_tmc_timer: self-checking bench of the timer mode counter
// assumes tmc_timer with AXI4-Lite registers; the checker is bound below
module test_tmc_timer
  import tmc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================================
  // signals
  typedef struct {
    logic [5:0] a;
    logic [31:0] d;
    logic [31:0] e;
    logic [1:0] r;
  } tmc_row_t;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [5:0] awaddr = 6'h00;
  logic [5:0] araddr = 6'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, irq, tout;
  logic [1:0] bresp, rresp, r;
  logic [31:0] rdata, x;
  logic [2:0] lvl;
  int err_total = 0;
  int n_checks = 0;
  int cyc = 0;
  int n;
  tmc_row_t rows [11] = '{
    '{tmc_off_run, 32'h04, 32'h00, tmc_resp_okay},
    '{tmc_off_irqc, 32'h0f, 32'h07, tmc_resp_okay},
    '{tmc_off_irqc, 32'h01, 32'h01, tmc_resp_okay},
    '{tmc_off_pre, 32'hf9, 32'hf9, tmc_resp_okay},
    '{tmc_off_pre, 32'h00, 32'h00, tmc_resp_okay},
    '{tmc_off_main, 32'h09, 32'h09, tmc_resp_okay},
    '{tmc_off_route, 32'h03, 32'h03, tmc_resp_okay},
    '{tmc_off_route, 32'h00, 32'h00, tmc_resp_okay},
    '{tmc_off_pio, 32'hff, 32'h3f, tmc_resp_okay},
    '{tmc_off_mode, 32'h91, 32'h91, tmc_resp_okay},
    '{6'h24, 32'h5a, 32'h00, tmc_resp_slverr}
  };
  always #5 aclk = ~aclk;
  tmc_timer i_tmc_timer (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .irq(irq), .irq_level(lvl), .timer_out(tout)
  );
  // ==========================================================================
  // tasks
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input logic [5:0] a, input logic [31:0] d, output logic [1:0] rs);
    logic ta, tw, da, dw;
    da = 1'b0;
    dw = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(da && dw)) begin
      @(negedge aclk);
      ta = awready && !da;
      tw = wready && !dw;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      da = da || ta;
      dw = dw || tw;
    end
    do @(negedge aclk); while (!bvalid);
    @(posedge aclk);
    bready <= 1'b1;
    @(negedge aclk);
    rs = bresp;
    @(posedge aclk);
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [5:0] a, output logic [31:0] v, output logic [1:0] rs);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    do @(negedge aclk); while (!arready);
    @(posedge aclk);
    arvalid <= 1'b0;
    do @(negedge aclk); while (!rvalid);
    @(posedge aclk);
    rready <= 1'b1;
    @(negedge aclk);
    v = rdata;
    rs = rresp;
    @(posedge aclk);
    rready <= 1'b0;
  endtask : rd
  task rc(input logic [5:0] a, input logic [31:0] e);
    rd(a, x, r);
    chk(x, e);
  endtask : rc
  task ck_irq(input logic e);
    repeat (2) @(negedge aclk);
    chk(irq, e);
  endtask : ck_irq
  task automatic gap(output int g);
    logic t;
    @(negedge aclk);
    t = tout;
    while (tout === t) @(negedge aclk);
    g = 0;
    t = tout;
    while (tout === t) begin
      @(negedge aclk);
      g++;
    end
  endtask : gap
  task automatic quiet;
    logic t;
    t = tout;
    repeat (400) @(negedge aclk);
    chk(tout, t);
  endtask : quiet
  task results;
    $display("errors %0d checks %0d", err_total, n_checks);
    if (err_total == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : results
  // ==========================================================================
  // sequence
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      err_total++;
      results();
    end
  end
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rc(tmc_off_pre, 32'hff);
    rc(tmc_off_main, 32'hff);
    rc(tmc_off_run, 32'h00);
    ck_irq(1'b0);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d, r);
      chk(r, rows[i].r);
      rd(rows[i].a, x, r);
      chk(x, rows[i].e);
      chk(r, rows[i].r);
    end
    // setup order: stop, irq off, halt, load, configure, irq on, start
    wr(tmc_off_run, 32'h00, r);
    wr(tmc_off_irqc, 32'h00, r);
    wr(tmc_off_run, 32'h04, r);
    wr(tmc_off_pre, 32'h09, r);
    wr(tmc_off_main, 32'h03, r);
    wr(tmc_off_route, 32'h00, r);
    wr(tmc_off_pio, 32'h00, r);
    wr(tmc_off_mode, 32'h10, r);
    wr(tmc_off_imask, 32'h01, r);
    wr(tmc_off_ists, 32'h01, r);
    wr(tmc_off_irqc, 32'h01, r);
    chk(lvl, 32'h1);
    wr(tmc_off_run, 32'h01, r);
    gap(n);
    chk(n, 320);
    ck_irq(1'b1);
    rc(tmc_off_ists, 32'h01);
    rc(tmc_off_irqc, 32'h09);
    rc(tmc_off_run, 32'h21);
    wr(tmc_off_run, 32'h04, r);
    rc(tmc_off_main, 32'h03);
    rc(tmc_off_run, 32'h00);
    quiet();
    wr(tmc_off_run, 32'h01, r);
    wr(tmc_off_mode, 32'h90, r);
    quiet();
    wr(tmc_off_mode, 32'h11, r);
    quiet();
    wr(tmc_off_mode, 32'h00, r);
    gap(n);
    chk(n, 40);
    wr(tmc_off_imask, 32'h00, r);
    wr(tmc_off_irqc, 32'h00, r);
    repeat (50) @(negedge aclk);
    ck_irq(1'b0);
    wr(tmc_off_imask, 32'h01, r);
    ck_irq(1'b1);
    wr(tmc_off_run, 32'h00, r);
    wr(tmc_off_ists, 32'h01, r);
    ck_irq(1'b0);
    wr(tmc_off_irqc, 32'h01, r);
    ck_irq(1'b0);
    rc(tmc_off_irqc, 32'h01);
    // reset in mid-run returns counters, level and irq to their reset state
    wr(tmc_off_run, 32'h01, r);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rc(tmc_off_main, 32'hff);
    rc(tmc_off_run, 32'h00);
    ck_irq(1'b0);
    chk(lvl, 32'h0);
    results();
  end
endmodule : test_tmc_timer
bind tmc_timer tmc_timer_props i_tmc_timer_props (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .irq_level(irq_level)
);
